// file: call_handling_status_node.sv
// Call-processing status register group: condition, filters, events, mask
`timescale 1ns/1ps
module call_handling_status_node
  import call_status_pkg::*;
#(
  parameter int unsigned WIDTH = REG_W
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Call-processing indications
  input wire logic active_on,
  input wire logic registering_on,
  input wire logic authenticating,
  input wire logic paging_on,
  input wire logic access_on,
  input wire logic connected_on,
  input wire logic base_call_past_access,
  input wire logic mobile_answered,
  // Command port from the remote command parser
  input wire logic cmd_write,
  input wire logic cmd_query,
  input wire logic [2:0] cmd_sel,
  input wire logic [WIDTH-1:0] cmd_wdata,
  input wire logic clear_status,
  // Answers and summary
  output logic [WIDTH-1:0] query_data,
  output logic query_valid,
  output logic group_summary_flag
);
  logic ringing;
  logic [WIDTH-1:0] call_state_live;
  logic [WIDTH-1:0] rising_edge_filter;
  logic [WIDTH-1:0] falling_edge_filter;
  logic [WIDTH-1:0] latched_call_events;
  logic [WIDTH-1:0] summary_mask;
  logic [WIDTH-1:0] next_live;
  logic [WIDTH-1:0] rise_hits;
  logic [WIDTH-1:0] fall_hits;
  logic [WIDTH-1:0] next_events;
  logic [WIDTH-1:0] read_mux;
  logic event_query;
  logic wr_rise;
  logic wr_fall;
  logic wr_mask;
  logic [WIDTH-1:0] next_mask;

  // Ringing: set wins if both arrive, since a new attempt outranks an answer
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ringing <= 1'b0;
    else if (base_call_past_access)
      ringing <= 1'b1;
    else if (mobile_answered)
      ringing <= 1'b0;
  end

  always_comb
  begin
    next_live = '0;
    next_live[BIT_ACTIVE] = active_on;
    next_live[BIT_REGISTER] = registering_on;
    next_live[BIT_AUTH] = authenticating;
    next_live[BIT_PAGE] = paging_on;
    next_live[BIT_ACCESS] = access_on;
    next_live[BIT_CONNECT] = connected_on;
    next_live[BIT_RINGING] = ringing;
  end

  assign event_query = cmd_query && (cmd_sel == SEL_EVENTS);
  assign wr_rise = cmd_write && (cmd_sel == SEL_RISE);
  assign wr_fall = cmd_write && (cmd_sel == SEL_FALL);
  assign wr_mask = cmd_write && (cmd_sel == SEL_MASK);
  // Flag looks ahead at the mask so a mask write never leaves it a cycle stale
  assign next_mask = wr_mask ? cmd_wdata : summary_mask;

  // Edge detection against the previous live snapshot
  assign rise_hits = next_live & ~call_state_live & rising_edge_filter;
  assign fall_hits = ~next_live & call_state_live
                     & falling_edge_filter;
  // New edges in the clearing cycle survive the clear
  assign next_events = ((event_query || clear_status) ? '0
                        : latched_call_events) | rise_hits | fall_hits;

  // Decoding the read select
  always_comb
  begin
    if (cmd_sel == SEL_LIVE)
      read_mux = call_state_live;
    else if (cmd_sel == SEL_RISE)
      read_mux = rising_edge_filter;
    else if (cmd_sel == SEL_FALL)
      read_mux = falling_edge_filter;
    else if (cmd_sel == SEL_EVENTS)
      read_mux = latched_call_events;
    else if (cmd_sel == SEL_MASK)
      read_mux = summary_mask;
    else
      read_mux = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      call_state_live <= RESET_LIVE;
      latched_call_events <= RESET_EVENTS;
    end
    else
    begin
      call_state_live <= next_live;
      latched_call_events <= next_events;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rising_edge_filter <= RESET_RISE;
      falling_edge_filter <= RESET_FALL;
      summary_mask <= RESET_MASK;
    end
    else
    begin
      if (wr_rise)
        rising_edge_filter <= cmd_wdata;
      if (wr_fall)
        falling_edge_filter <= cmd_wdata;
      if (wr_mask)
        summary_mask <= cmd_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      query_data <= '0;
      query_valid <= 1'b0;
      group_summary_flag <= 1'b0;
    end
    else
    begin
      query_valid <= cmd_query;
      if (cmd_query)
        query_data <= read_mux;
      group_summary_flag <= |(next_events & next_mask);
    end
  end

  chk_live_top_zero: assert property (
    @(posedge sys_clk) disable iff (srst)
    call_state_live[WIDTH-1:USED_BITS] == '0)
    else $error("unused condition bits not zero");
  chk_unused_bits: assert property (
    @(posedge sys_clk) disable iff (srst)
    latched_call_events[WIDTH-1:USED_BITS] == '0)
    else $error("unused event bits set");
  chk_ring_set: assert property (
    @(posedge sys_clk) disable iff (srst)
    base_call_past_access |=> ##1 call_state_live[BIT_RINGING])
    else $error("ringing bit not set");
  chk_ring_clear: assert property (
    @(posedge sys_clk) disable iff (srst)
    mobile_answered && !base_call_past_access
      |=> ##1 !call_state_live[BIT_RINGING])
    else $error("ringing bit not cleared");
  chk_connect_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 call_state_live[BIT_CONNECT] == $past(connected_on))
    else $error("connect bit does not follow");
  chk_access_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 call_state_live[BIT_ACCESS] == $past(access_on))
    else $error("access bit does not follow");
  chk_page_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 call_state_live[BIT_PAGE] == $past(paging_on))
    else $error("page bit does not follow");
  chk_auth_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    authenticating |=> call_state_live[BIT_AUTH])
    else $error("auth bit not high");
  chk_reg_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 call_state_live[BIT_REGISTER] == $past(registering_on))
    else $error("register bit does not follow");
  chk_active_follow: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 call_state_live[BIT_ACTIVE] == $past(active_on))
    else $error("active bit does not follow");
  chk_event_clear: assert property (
    @(posedge sys_clk) disable iff (srst)
    (event_query || clear_status) && rise_hits == '0 && fall_hits == '0
      |=> latched_call_events == '0)
    else $error("events not cleared");
  chk_filter_store: assert property (
    @(posedge sys_clk) disable iff (srst)
    wr_rise |=> rising_edge_filter == $past(cmd_wdata))
    else $error("rise filter not stored");
  chk_fall_store: assert property (
    @(posedge sys_clk) disable iff (srst)
    wr_fall |=> falling_edge_filter == $past(cmd_wdata))
    else $error("fall filter not stored");
  chk_mask_store: assert property (
    @(posedge sys_clk) disable iff (srst)
    wr_mask |=> summary_mask == $past(cmd_wdata))
    else $error("mask not stored");
  chk_mask_answer: assert property (
    @(posedge sys_clk) disable iff (srst)
    cmd_query && cmd_sel == SEL_MASK
      |=> query_valid && query_data == $past(summary_mask))
    else $error("mask readback wrong");
  chk_edge_latch: assert property (
    @(posedge sys_clk) disable iff (srst)
    (rise_hits | fall_hits) != '0
      |=> (latched_call_events & $past(rise_hits | fall_hits))
          == $past(rise_hits | fall_hits))
    else $error("edge not latched");
  chk_summary_flag: assert property (
    @(posedge sys_clk) disable iff (srst)
    ##1 group_summary_flag == |(latched_call_events & summary_mask))
    else $error("summary flag wrong");
endmodule

// file: call_handling_status_node_test.sv
// Randomised self-checking bench for the call status register group
`timescale 1ns/1ps
module call_handling_status_node_test
  import call_status_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] ind = 8'h00;
  logic cmd_write, cmd_query, clear_status, query_valid, flag;
  logic [2:0] cmd_sel;
  logic [15:0] cmd_wdata, query_data, rise, fall, mask, ev, old, cur;
  logic ring = 1'b0;
  int err_count = 0;
  int compares = 0;
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  call_handling_status_node DUT (.sys_clk(sys_clk), .srst(srst),
    .active_on(ind[0]), .registering_on(ind[1]), .authenticating(ind[2]),
    .paging_on(ind[3]), .access_on(ind[4]), .connected_on(ind[5]),
    .base_call_past_access(ind[6]), .mobile_answered(ind[7]),
    .cmd_write(cmd_write), .cmd_query(cmd_query), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .clear_status(clear_status),
    .query_data(query_data), .query_valid(query_valid),
    .group_summary_flag(flag));
  status_controller ctl (.sys_clk(sys_clk), .cmd_write(cmd_write),
    .cmd_query(cmd_query), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .clear_status(clear_status), .query_data(query_data),
    .query_valid(query_valid));
  function automatic logic [15:0] live_of(input logic [7:0] v, input logic r);
    live_of = {9'h000, r, v[5:0]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    ctl.ask(sel, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, exp);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    logic [15:0] rst_exp [5];
    rst_exp = '{RESET_LIVE, RESET_RISE, RESET_FALL, RESET_EVENTS, RESET_MASK};
    void'($urandom(32'hb46f));
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    for (int s = 0; s < 8; s++)
      rd(3'(s), (s < 5) ? rst_exp[s] : 16'h0000);
    rise = 16'($urandom);
    fall = 16'($urandom);
    mask = 16'($urandom);
    ctl.put(SEL_RISE, rise);
    ctl.put(SEL_FALL, fall);
    ctl.put(SEL_MASK, mask);
    ctl.put(SEL_LIVE, 16'hffff);
    ctl.put(SEL_EVENTS, 16'hffff);
    rd(SEL_RISE, rise);
    rd(SEL_FALL, fall);
    rd(SEL_MASK, mask);
    rd(SEL_EVENTS, 16'h0000);
    ev = 16'h0000;
    for (int i = 0; i < 60; i++)
    begin
      old = live_of(ind, ring);
      ind = 8'($urandom);
      if (i % 9 == 0)
        ind[7:6] = 2'b11;
      ring = ind[6] ? 1'b1 : (ind[7] ? 1'b0 : ring);
      cur = live_of(ind, ring);
      ev |= (cur & ~old & rise) | (~cur & old & fall);
      repeat (3) @(posedge sys_clk);
      rd(SEL_LIVE, cur);
      check({15'h0000, flag}, {15'h0000, |(ev & mask)});
      if (i % 4 == 3)
      begin
        rd(SEL_EVENTS, ev);
        ev = 16'h0000;
        rd(SEL_EVENTS, ev);
      end
      if (i % 7 == 6)
      begin
        ctl.cls();
        ev = 16'h0000;
        check({15'h0000, flag}, 16'h0000);
      end
      if (i % 10 == 5)
      begin
        mask = 16'($urandom);
        ctl.put(SEL_MASK, mask);
        check({15'h0000, flag}, {15'h0000, |(ev & mask)});
      end
    end
    rd(SEL_EVENTS, ev);
    tally_and_finish();
  end
endmodule

// file: call_status_pkg.sv
// Register selects, bit positions and reset values of the call status group
package call_status_pkg;
  localparam int unsigned REG_W = 16;
  // Register selects for the command port
  localparam logic [2:0] SEL_LIVE = 3'h0;
  localparam logic [2:0] SEL_RISE = 3'h1;
  localparam logic [2:0] SEL_FALL = 3'h2;
  localparam logic [2:0] SEL_EVENTS = 3'h3;
  localparam logic [2:0] SEL_MASK = 3'h4;
  // Condition bit positions
  localparam int unsigned BIT_ACTIVE = 0;
  localparam int unsigned BIT_REGISTER = 1;
  localparam int unsigned BIT_AUTH = 2;
  localparam int unsigned BIT_PAGE = 3;
  localparam int unsigned BIT_ACCESS = 4;
  localparam int unsigned BIT_CONNECT = 5;
  localparam int unsigned BIT_RINGING = 6;
  localparam int unsigned USED_BITS = 7;
  // Values after reset
  localparam logic [15:0] RESET_RISE = 16'h7fff;
  localparam logic [15:0] RESET_FALL = 16'h0000;
  localparam logic [15:0] RESET_EVENTS = 16'h0000;
  localparam logic [15:0] RESET_MASK = 16'h0000;
  localparam logic [15:0] RESET_LIVE = 16'h0000;
endpackage

// file: status_controller.sv
// Remote controller model issuing register writes, queries and clear-status
`timescale 1ns/1ps
module status_controller
  import call_status_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Command port toward the group
  output logic cmd_write,
  output logic cmd_query,
  output logic [2:0] cmd_sel,
  output logic [REG_W-1:0] cmd_wdata,
  output logic clear_status,
  // Answers
  input wire logic [REG_W-1:0] query_data,
  input wire logic query_valid
);
  initial
  begin
    cmd_write = 1'b0;
    cmd_query = 1'b0;
    cmd_sel = 3'h7;
    cmd_wdata = 16'h5a5a;
    clear_status = 1'b0;
  end
  // Released data and selects are inverted; the inverse of SEL_MASK or SEL_EVENTS is still a valid select
  task automatic put(input logic [2:0] sel, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    cmd_sel = sel;
    cmd_wdata = d;
    cmd_write = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_write = 1'b0;
    cmd_wdata = ~d;
    cmd_sel = ~sel;
  endtask
  task automatic ask(input logic [2:0] sel, output logic [15:0] d,
                     output logic ok);
    @(posedge sys_clk);
    #1;
    cmd_sel = sel;
    cmd_query = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_query = 1'b0;
    cmd_sel = ~sel;
    ok = query_valid;
    d = query_data;
  endtask
  task automatic cls();
    @(posedge sys_clk);
    #1;
    clear_status = 1'b1;
    @(posedge sys_clk);
    #1;
    clear_status = 1'b0;
  endtask
endmodule
